// file: pkg/seehl_params.svh
// offsets, field positions, reset values and widths of the header log bank
// assumes inclusion by bare name from the design and dv files
`ifndef SEEHL_PARAMS_SVH
`define SEEHL_PARAMS_SVH

// apb byte addresses of the bank
`define SEEHL_ADDR_W        12
`define SEEHL_OFF_FIRST_PTR 12'h138
`define SEEHL_OFF_ATTR_LO   12'h13C
`define SEEHL_OFF_CMD_ATTR  12'h140
`define SEEHL_OFF_ADDR_LO   12'h144
`define SEEHL_OFF_ADDR_HI   12'h148
`define SEEHL_OFF_IRQ_STAT  12'h150
`define SEEHL_OFF_IRQ_MASK  12'h154

// field positions inside the command/attribute word
`define SEEHL_CMD_HI_LSB    8
`define SEEHL_CMD_LO_LSB    4
`define SEEHL_ATTR_HI_LSB   0

// widths
`define SEEHL_PTR_W         5
`define SEEHL_IRQ_W         2

// interrupt status bit positions
`define SEEHL_STAT_LOGGED   0
`define SEEHL_STAT_DROPPED  1

// reset values
`define SEEHL_RST_WORD      32'h0000_0000
`define SEEHL_RST_PTR       5'h00
`define SEEHL_RST_IRQ       2'h0

`endif

// file: pkg/seehl_pkg.sv
// types shared by the header log bank and its capture stage
// assumes the params header sits beside it on the include path
package seehl_pkg;

   // kind of bus phase presented by the secondary bus tracker
   typedef enum logic [1:0] {
      SEEHL_PH_ADDR1 = 2'b00,
      SEEHL_PH_ADDR2 = 2'b01,
      SEEHL_PH_ATTR  = 2'b10
   } seehl_phase_e;

   // occupancy of the header log
   typedef enum logic {
      SEEHL_LOG_EMPTY = 1'b0,
      SEEHL_LOG_HELD  = 1'b1
   } seehl_log_e;

   typedef logic [35:0] seehl_attr_t;

endpackage : seehl_pkg

// file: pkg/seehl_hdr_if.sv
// header snapshot carried from the capture stage to the log bank
// assumes both ends share the core clock
`timescale 1ns/1ps
interface seehl_hdr_if;
   logic [3:0]          cmd_lo;
   logic [3:0]          cmd_hi;
   seehl_pkg::seehl_attr_t attr;
   logic [31:0]         addr_lo;
   logic [31:0]         addr_hi;

   modport src (output cmd_lo, output cmd_hi, output attr, output addr_lo, output addr_hi);
   modport snk (input cmd_lo, input cmd_hi, input attr, input addr_lo, input addr_hi);
endinterface : seehl_hdr_if

// file: core/seehl_capture.sv
// capture stage: keeps the header of the transaction now on the secondary bus
// assumes phase strobes are one cycle and synchronous to the core clock
`timescale 1ns/1ps
`include "seehl_params.svh"
module seehl_capture (
   // clock and reset
   input  wire logic                 i_clk,
   input  wire logic                 i_rst_n,
   // bus phase tracker
   input  wire logic                 i_phase_valid,
   input  wire seehl_pkg::seehl_phase_e i_phase,
   input  wire logic [3:0]           i_cbe_n,
   input  wire logic [31:0]          i_ad,
   // snapshot towards the log bank
   seehl_hdr_if.src                  hdr
);

   logic [3:0]             cmd_lo_r;
   logic [3:0]             cmd_hi_r;
   seehl_pkg::seehl_attr_t attr_r;
   logic [31:0]            addr_lo_r;
   logic [31:0]            addr_hi_r;

   // a first address phase starts a new transaction, so the dac half is wiped
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cmd_lo_r  <= 4'h0;
         cmd_hi_r  <= 4'h0;
         attr_r    <= 36'h0_0000_0000;
         addr_lo_r <= `SEEHL_RST_WORD;
         addr_hi_r <= `SEEHL_RST_WORD;
      end else if (i_phase_valid) begin
         unique case (i_phase)
            seehl_pkg::SEEHL_PH_ADDR1: begin
               cmd_lo_r  <= i_cbe_n;
               addr_lo_r <= i_ad;
               addr_hi_r <= `SEEHL_RST_WORD;
               cmd_hi_r  <= 4'h0;
            end
            seehl_pkg::SEEHL_PH_ADDR2: begin
               cmd_hi_r  <= i_cbe_n;
               addr_hi_r <= i_ad;
            end
            seehl_pkg::SEEHL_PH_ATTR: begin
               attr_r    <= {i_cbe_n, i_ad};
            end
            default: begin
               attr_r    <= attr_r;             // illegal phase code ignored
            end
         endcase
      end
   end

   // snapshot outputs straight from flops
   assign hdr.cmd_lo  = cmd_lo_r;
   assign hdr.cmd_hi  = cmd_hi_r;
   assign hdr.attr    = attr_r;
   assign hdr.addr_lo = addr_lo_r;
   assign hdr.addr_hi = addr_hi_r;

endmodule : seehl_capture

// file: core/seehl_top.sv
// secondary bus error header log bank with apb slave and interrupt
// assumes apb from the core clock domain and error strobes one cycle wide
// and that the params header and the package are compiled first
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "seehl_params.svh"
module seehl_top (
   // clock and resets
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_RST_N,
   input  wire logic        I_WARM_RST_N,
   // apb slave
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [11:0] I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic      [31:0] O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   // secondary bus phase tracker
   input  wire logic        I_PHASE_VALID,
   input  wire logic [1:0]  I_PHASE,
   input  wire logic [3:0]  I_CBE_N,
   input  wire logic [31:0] I_AD,
   // uncorrectable error reports
   input  wire logic        I_ERR_VALID,
   input  wire logic [4:0]  I_ERR_ID,
   // interrupt
   output logic             O_IRQ
);

   // widths from the params header, named here for readability
   localparam int PTR_W = `SEEHL_PTR_W;
   localparam int IRQ_W = `SEEHL_IRQ_W;

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------

   // reset groups: logs and capture stage follow power reset only, the rest any reset
   logic                   rst_any_n;

   // snapshot of the current transaction
   seehl_hdr_if            hdr ();

   // log state
   seehl_pkg::seehl_log_e  log_state_r;
   seehl_pkg::seehl_log_e  log_state_nxt;
   logic [PTR_W-1:0]       first_ptr_r;
   logic [3:0]             log_cmd_lo_r;
   logic [3:0]             log_cmd_hi_r;
   seehl_pkg::seehl_attr_t log_attr_r;
   logic [31:0]            log_addr_lo_r;
   logic [31:0]            log_addr_hi_r;
   logic                   commit;
   logic                   drop;
   logic                   rearm;

   // apb decode
   logic                   apb_setup;
   logic                   apb_access;
   logic                   apb_wr;
   logic                   addr_hit;
   logic                   wr_stat;
   logic                   wr_mask;
   logic [31:0]            rd_word;
   logic [31:0]            prdata_r;
   logic                   pslverr_r;

   // interrupt registers
   logic [IRQ_W-1:0]       irq_stat_r;
   logic [IRQ_W-1:0]       irq_stat_nxt;
   logic [IRQ_W-1:0]       irq_mask_r;
   logic [IRQ_W-1:0]       irq_set;
   logic [IRQ_W-1:0]       irq_clr;

   // ------------------------------------------------------------------
   // functions
   // ------------------------------------------------------------------

   // true when the byte address names a register of this bank
   // a miss raises pslverr and has no other effect
   function automatic logic is_mapped(input logic [11:0] addr);
      logic hit;
      hit = 1'b0;
      unique case (addr)
         `SEEHL_OFF_FIRST_PTR,
         `SEEHL_OFF_ATTR_LO,
         `SEEHL_OFF_CMD_ATTR,
         `SEEHL_OFF_ADDR_LO,
         `SEEHL_OFF_ADDR_HI,
         `SEEHL_OFF_IRQ_STAT,
         `SEEHL_OFF_IRQ_MASK: hit = 1'b1;
         default:             hit = 1'b0;
      endcase
      return hit;
   endfunction : is_mapped

   // sticky flag update where a set in the clearing cycle wins
   // the same rule serves both status bits
   function automatic logic [IRQ_W-1:0] sticky_next(
      input logic [IRQ_W-1:0] cur,
      input logic [IRQ_W-1:0] set,
      input logic [IRQ_W-1:0] clr
   );
      return (cur & ~clr) | set;
   endfunction : sticky_next

   // pack the command/attribute log word
   // reserved bits 31:12 stay zero
   function automatic logic [31:0] pack_cmd_attr(
      input logic [3:0] cmd_hi,
      input logic [3:0] cmd_lo,
      input logic [3:0] attr_hi
   );
      logic [31:0] w;
      w = `SEEHL_RST_WORD;
      w[`SEEHL_CMD_HI_LSB +: 4]  = cmd_hi;
      w[`SEEHL_CMD_LO_LSB +: 4]  = cmd_lo;
      w[`SEEHL_ATTR_HI_LSB +: 4] = attr_hi;
      return w;
   endfunction : pack_cmd_attr

   // ------------------------------------------------------------------
   // capture stage
   // ------------------------------------------------------------------

   // the stage follows power reset only, so a warm reset in mid
   // transaction cannot leave a header with half its phases
   // the phase code is cast once here; the stage drops an illegal code
   seehl_capture u_capture (
      .i_clk         (I_SYS_CLK),
      .i_rst_n       (I_RST_N),
      .i_phase_valid (I_PHASE_VALID),
      .i_phase       (seehl_pkg::seehl_phase_e'(I_PHASE)),
      .i_cbe_n       (I_CBE_N),
      .i_ad          (I_AD),
      .hdr           (hdr)
   );

   // ------------------------------------------------------------------
   // resets
   // ------------------------------------------------------------------

   // limitation: after a warm reset the log stays held until software
   // writes one to status bit 0, although that bit then reads zero
   // a warm reset clears software-facing state but spares the logs
   assign rst_any_n = I_RST_N & I_WARM_RST_N;

   // ------------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------------

   // pready is tied high, so each access phase lasts one cycle
   // setup and access phases of a transfer
   assign apb_setup  = I_PSEL & ~I_PENABLE;
   assign apb_access = I_PSEL & I_PENABLE;
   assign apb_wr     = apb_access & I_PWRITE & addr_hit;
   assign addr_hit   = is_mapped(I_PADDR);

   // write strobes of the two writable registers
   assign wr_stat = apb_wr && (I_PADDR == `SEEHL_OFF_IRQ_STAT);
   assign wr_mask = apb_wr && (I_PADDR == `SEEHL_OFF_IRQ_MASK);

   // rearm by writing one to the logged status bit
   assign rearm   = wr_stat && I_PWDATA[`SEEHL_STAT_LOGGED];

   // w1c strobes of the interrupt status
   assign irq_clr = wr_stat ? I_PWDATA[IRQ_W-1:0] : `SEEHL_RST_IRQ;

   // ------------------------------------------------------------------
   // log control
   // ------------------------------------------------------------------

   // a phase strobe reaches the snapshot one edge later, so an error
   // must trail the last strobe of its transaction by a cycle or the
   // log picks up the previous attribute or address
   // a drop only sets status bit 1; its error index is lost
   // only the first error after a rearm lands in the log
   assign commit = I_ERR_VALID && (log_state_r == seehl_pkg::SEEHL_LOG_EMPTY);
   assign drop   = I_ERR_VALID && (log_state_r == seehl_pkg::SEEHL_LOG_HELD);

   // a held log ignores further errors until software rearms it
   // next log state; rearm and a new error may meet in one cycle
   always_comb begin
      log_state_nxt = log_state_r;
      unique case (log_state_r)
         seehl_pkg::SEEHL_LOG_EMPTY: begin
            if (commit) begin
               log_state_nxt = seehl_pkg::SEEHL_LOG_HELD;
            end
         end
         seehl_pkg::SEEHL_LOG_HELD: begin
            if (rearm) begin
               log_state_nxt = seehl_pkg::SEEHL_LOG_EMPTY;
            end
         end
      endcase
   end

   // a rearm while empty changes nothing, so a stray write is harmless
   // log state survives warm reset so the held header is not reopened
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         log_state_r <= seehl_pkg::SEEHL_LOG_EMPTY;
      end else begin
         log_state_r <= log_state_nxt;
      end
   end

   // the pointer moves only with a commit, so it always matches the header
   // first error pointer, sticky across warm reset
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         first_ptr_r <= `SEEHL_RST_PTR;
      end else if (commit) begin
         first_ptr_r <= I_ERR_ID;
      end
   end

   // all five fields load on one edge, so no half-written header is seen
   // header log fields; software has no write path into them
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         log_cmd_lo_r  <= 4'h0;
         log_cmd_hi_r  <= 4'h0;
         log_attr_r    <= 36'h0_0000_0000;
         log_addr_lo_r <= `SEEHL_RST_WORD;
         log_addr_hi_r <= `SEEHL_RST_WORD;
      end else if (commit) begin
         log_cmd_lo_r  <= hdr.cmd_lo;
         log_cmd_hi_r  <= hdr.cmd_hi;
         log_attr_r    <= hdr.attr;
         log_addr_lo_r <= hdr.addr_lo;
         log_addr_hi_r <= hdr.addr_hi;
      end
   end

   // ------------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------------

   // both events are one-cycle pulses from the log control
   // events: header logged, error seen while the log was full
   always_comb begin
      irq_set                      = `SEEHL_RST_IRQ;
      irq_set[`SEEHL_STAT_LOGGED]  = commit;
      irq_set[`SEEHL_STAT_DROPPED] = drop;
   end

   assign irq_stat_nxt = sticky_next(irq_stat_r, irq_set, irq_clr);

   // warm reset clears it too, since software sets up again after one
   // status clears on any reset; an event in the clear cycle is kept
   always_ff @(posedge I_SYS_CLK) begin
      if (!rst_any_n) begin
         irq_stat_r <= `SEEHL_RST_IRQ;
      end else begin
         irq_stat_r <= irq_stat_nxt;
      end
   end

   // reset leaves every source masked, so no interrupt before set-up
   // mask register, a one enables the matching status bit
   always_ff @(posedge I_SYS_CLK) begin
      if (!rst_any_n) begin
         irq_mask_r <= `SEEHL_RST_IRQ;
      end else if (wr_mask) begin
         irq_mask_r <= I_PWDATA[IRQ_W-1:0];
      end
   end

   // trade-off: no output flop, so the line falls at the clearing edge
   // and software never takes a stale second interrupt
   // level interrupt; combinational from flops so it drops with the clear
   assign O_IRQ = |(irq_stat_r & irq_mask_r);

   // ------------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------------

   // map: 0x138 pointer 4:0, 0x13C attribute 31:0,
   //   0x140 commands 11:8 and 7:4, attribute 35:32 in 3:0,
   //   0x144 address 31:0, 0x148 address 63:32,
   //   0x150 status w1c, 0x154 mask
   // status bit 0: header logged; bit 1: error while the log was held
   // reads have no side effect, so software may poll the logs freely
   // the pointer and the status words zero-extend to 32 bits
   // reserved bits read as zero
   always_comb begin
      rd_word = `SEEHL_RST_WORD;
      unique case (I_PADDR)
         `SEEHL_OFF_FIRST_PTR: rd_word[PTR_W-1:0] = first_ptr_r;
         `SEEHL_OFF_ATTR_LO:   rd_word = log_attr_r[31:0];
         `SEEHL_OFF_CMD_ATTR:  rd_word = pack_cmd_attr(log_cmd_hi_r, log_cmd_lo_r,
                                                       log_attr_r[35:32]);
         `SEEHL_OFF_ADDR_LO:   rd_word = log_addr_lo_r;
         `SEEHL_OFF_ADDR_HI:   rd_word = log_addr_hi_r;
         `SEEHL_OFF_IRQ_STAT:  rd_word[IRQ_W-1:0] = irq_stat_r;
         `SEEHL_OFF_IRQ_MASK:  rd_word[IRQ_W-1:0] = irq_mask_r;
         default:              rd_word = `SEEHL_RST_WORD;
      endcase
   end

   // write cycles load zero so stale read data never lingers
   // read data and error are set up during the setup cycle, so the
   // access phase completes with no wait state and data from a flop
   always_ff @(posedge I_SYS_CLK) begin
      if (!rst_any_n) begin
         prdata_r  <= `SEEHL_RST_WORD;
         pslverr_r <= 1'b0;
      end else if (apb_setup) begin
         prdata_r  <= I_PWRITE ? `SEEHL_RST_WORD : rd_word;
         pslverr_r <= ~addr_hit;
      end
   end

   // ------------------------------------------------------------------
   // apb outputs
   // ------------------------------------------------------------------

   // limitation: only an address outside the bank raises pslverr
   // writes to the read-only logs are accepted and ignored
   assign O_PREADY  = 1'b1;
   assign O_PRDATA  = prdata_r;
   assign O_PSLVERR = pslverr_r & apb_access;

endmodule : seehl_top

// file: dv/seehl_properties.sv
// checker of the header log bank ports: shadows log, status and mask words
// assumes one core clock; bound to the top module at the foot of this file
`timescale 1ns/1ps
`include "seehl_params.svh"
module seehl_properties (
   // clock and resets
   input wire logic        I_SYS_CLK,
   input wire logic        I_RST_N,
   input wire logic        I_WARM_RST_N,
   // apb
   input wire logic        I_PSEL,
   input wire logic        I_PENABLE,
   input wire logic        I_PWRITE,
   input wire logic [11:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [31:0] O_PRDATA,
   input wire logic        O_PREADY,
   input wire logic        O_PSLVERR,
   // phases, errors, interrupt
   input wire logic        I_PHASE_VALID,
   input wire logic [1:0]  I_PHASE,
   input wire logic [3:0]  I_CBE_N,
   input wire logic [31:0] I_AD,
   input wire logic        I_ERR_VALID,
   input wire logic [4:0]  I_ERR_ID,
   input wire logic        O_IRQ
);
   logic [3:0]  sclo_r, schi_r, sath_r, lclo_r, lchi_r, lath_r;
   logic [31:0] satl_r, salo_r, sahi_r, latl_r, lalo_r, lahi_r;
   logic [4:0]  lptr_r;
   logic [1:0]  stat_r, mask_r, w1c;
   logic        sdac_r, ldac_r, held_r, wr, rd, cm;

   assign wr  = I_PSEL & I_PENABLE & I_PWRITE;
   assign rd  = I_PSEL & I_PENABLE & ~I_PWRITE;
   assign cm  = I_ERR_VALID & ~held_r;  // only a first error commits
   assign w1c = (wr && I_PADDR == `SEEHL_OFF_IRQ_STAT) ? I_PWDATA[1:0] : 2'h0;

   // snapshot and log; warm reset leaves both alone
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N) begin
         {sclo_r, schi_r, sath_r, satl_r, salo_r, sahi_r, sdac_r} <= '0;
         {lclo_r, lchi_r, lath_r, latl_r, lalo_r, lahi_r, ldac_r, lptr_r, held_r} <= '0;
      end else begin
         if (I_PHASE_VALID && I_PHASE == 2'h0) begin
            {sclo_r, salo_r, schi_r, sahi_r, sdac_r} <= {I_CBE_N, I_AD, 37'h0};
         end
         if (I_PHASE_VALID && I_PHASE == 2'h1) begin
            {schi_r, sahi_r, sdac_r} <= {I_CBE_N, I_AD, 1'b1};
         end
         if (I_PHASE_VALID && I_PHASE == 2'h2) begin
            {sath_r, satl_r} <= {I_CBE_N, I_AD};
         end
         if (w1c[0]) begin
            held_r <= 1'b0;
         end
         if (cm) begin
            {lclo_r, lchi_r, lath_r, latl_r, lalo_r, lahi_r, ldac_r, lptr_r, held_r} <=
               {sclo_r, schi_r, sath_r, satl_r, salo_r, sahi_r, sdac_r, I_ERR_ID, 1'b1};
         end
      end
   end

   // a status set wins over a clear in the same cycle
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_N || !I_WARM_RST_N) begin
         {stat_r, mask_r} <= '0;
      end else begin
         stat_r <= (stat_r & ~w1c) | {I_ERR_VALID & held_r, cm};
         if (wr && I_PADDR == `SEEHL_OFF_IRQ_MASK) begin
            mask_r <= I_PWDATA[1:0];
         end
      end
   end

   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RST_N);

   // read data is the word as it stood at the setup edge, hence $past
   AST_CMD_HI: assert property (rd && I_PADDR == `SEEHL_OFF_CMD_ATTR |-> O_PRDATA[11:8] == $past(lchi_r))
      else $error("bad second command");
   AST_CMD_LO: assert property (rd && I_PADDR == `SEEHL_OFF_CMD_ATTR |-> O_PRDATA[7:4] == $past(lclo_r))
      else $error("bad first command");
   AST_ATTR_HI: assert property (rd && I_PADDR == `SEEHL_OFF_CMD_ATTR |->
      O_PRDATA[3:0] == $past(lath_r) && O_PRDATA[31:12] == 20'h0) else $error("bad attribute nibble");
   AST_ADDR_LO: assert property (rd && I_PADDR == `SEEHL_OFF_ADDR_LO |-> O_PRDATA == $past(lalo_r))
      else $error("bad low address");
   AST_ADDR_HI: assert property (rd && I_PADDR == `SEEHL_OFF_ADDR_HI && $past(ldac_r) |->
      O_PRDATA == $past(lahi_r)) else $error("bad high address");
   AST_ADDR_ZERO: assert property (rd && I_PADDR == `SEEHL_OFF_ADDR_HI && !$past(ldac_r) |->
      O_PRDATA == 32'h0000_0000) else $error("stale high address");
   AST_ATTR_LO: assert property (rd && I_PADDR == `SEEHL_OFF_ATTR_LO |-> O_PRDATA == $past(latl_r))
      else $error("bad attribute word");
   AST_PTR: assert property (rd && I_PADDR == `SEEHL_OFF_FIRST_PTR |-> O_PRDATA == {27'h0, $past(lptr_r)})
      else $error("bad first error pointer");
   AST_IRQ: assert property (O_IRQ == |(stat_r & mask_r))
      else $error("interrupt level wrong");

   cover property (cm);
   cover property (I_ERR_VALID && held_r);
   cover property (rd && I_PADDR == `SEEHL_OFF_ADDR_HI && ldac_r);
endmodule : seehl_properties

bind seehl_top seehl_properties i_seehl_properties (
   .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_WARM_RST_N(I_WARM_RST_N), .I_PSEL(I_PSEL),
   .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
   .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_PHASE_VALID(I_PHASE_VALID),
   .I_PHASE(I_PHASE), .I_CBE_N(I_CBE_N), .I_AD(I_AD), .I_ERR_VALID(I_ERR_VALID),
   .I_ERR_ID(I_ERR_ID), .O_IRQ(O_IRQ));

// file: dv/seehl_bus_agent.sv
// model of the secondary bus agents: sends one header per request
// assumes the core clock; idle cycles strobe the unused phase code on toggled lines
`timescale 1ns/1ps
module seehl_bus_agent (
   // clock and request
   input  wire logic        i_clk,
   input  wire logic        i_go,
   input  wire logic        i_dac,
   input  wire logic [3:0]  i_cmd1,
   input  wire logic [3:0]  i_cmd2,
   input  wire logic [63:0] i_addr,
   input  wire logic [35:0] i_attr,
   // phase strobes
   output logic             o_vld,
   output logic [1:0]       o_ph,
   output logic [3:0]       o_cbe_n,
   output logic [31:0]      o_ad,
   output logic             o_busy
);
   logic [1:0] st_r;

   initial begin
      {st_r, o_vld, o_ph, o_cbe_n, o_ad} = '0;
   end
   assign o_busy = (st_r != 2'h0) | (o_vld & (o_ph != 2'h3));

   // address phase, optional second address phase, attribute phase
   always @(posedge i_clk) begin
      {o_vld, o_ph, o_cbe_n, o_ad} <= {3'h7, ~o_cbe_n, ~o_ad};  // illegal code must be ignored
      case (st_r)
         2'h0: if (i_go) begin
            {o_vld, o_ph, o_cbe_n, o_ad} <= {3'h4, i_cmd1, i_addr[31:0]};
            st_r <= i_dac ? 2'h1 : 2'h2;
         end
         2'h1: begin
            {o_vld, o_ph, o_cbe_n, o_ad} <= {3'h5, i_cmd2, i_addr[63:32]};
            st_r <= 2'h2;
         end
         default: begin
            {o_vld, o_ph, o_cbe_n, o_ad} <= {3'h6, i_attr};
            st_r <= 2'h0;
         end
      endcase
   end
endmodule : seehl_bus_agent

// file: dv/seehl_top_tb.sv
// self-checking bench: random headers, first-error capture, both resets
// assumes the agent model and the bound checker are compiled first
`timescale 1ns/1ps
`include "seehl_params.svh"
module seehl_top_tb;
   logic        clk, rst_n, wrst_n, psel, pen, pwr, go, dac, ev, lerr, pready, pslverr, irq, vld, busy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, ad, q;
   logic [1:0]  ph, mask;
   logic [3:0]  cbe, c1, c2;
   logic [4:0]  eid;
   logic [63:0] adr;
   logic [35:0] att;
   logic [31:0] exp_w [5];
   integer      seed = 6598;
   integer      fails = 0;
   integer      n_checks = 0;

   seehl_top i_seehl_top (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_WARM_RST_N(wrst_n), .I_PSEL(psel),
      .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .I_PHASE_VALID(vld), .I_PHASE(ph), .I_CBE_N(cbe),
      .I_AD(ad), .I_ERR_VALID(ev), .I_ERR_ID(eid), .O_IRQ(irq));
   seehl_bus_agent i_seehl_bus_agent (.i_clk(clk), .i_go(go), .i_dac(dac), .i_cmd1(c1), .i_cmd2(c2),
      .i_addr(adr), .i_attr(att), .o_vld(vld), .o_ph(ph), .o_cbe_n(cbe), .o_ad(ad), .o_busy(busy));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         fails++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // one apb transfer; read data and error taken at the pready edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      integer n;
      n = 0;
      @(posedge clk);
      {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         fails++;
         tally_and_finish();
      end
      {q, lerr} = {prdata, pslverr};
      {psel, pen} <= 2'b00;
   endtask : apb

   task automatic readall;
      for (int k = 0; k < 5; k++) begin
         apb(1'b0, `SEEHL_OFF_FIRST_PTR + 12'(4 * k), 32'h0000_0000);
         check(q, exp_w[k]);
      end
   endtask : readall

   // expected words for the header just sent
   function automatic void build;
      exp_w[0] = {27'h0, eid};
      exp_w[1] = att[31:0];
      exp_w[2] = {20'h0, dac ? c2 : 4'h0, c1, att[35:32]};
      exp_w[3] = adr[31:0];
      exp_w[4] = dac ? adr[63:32] : 32'h0000_0000;
   endfunction : build

   // random header, then an error report one idle cycle later
   task automatic txn(input logic d);
      integer n;
      n = 0;
      @(posedge clk);
      {go, dac, c1, c2, eid} <= {1'b1, d, 13'($random(seed))};
      {adr, att} <= {$random(seed), $random(seed), $random(seed), 4'($random(seed))};
      @(posedge clk);
      go <= 1'b0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (busy && n < 16);
      if (busy) begin
         fails++;
         tally_and_finish();
      end
      @(posedge clk);
      ev <= 1'b1;
      @(posedge clk);
      ev <= 1'b0;
      #1;
   endtask : txn

   initial begin
      {rst_n, wrst_n, psel, pen, pwr, go, dac, ev, paddr, pwdata, c1, c2, eid, adr, att} = '0;
      exp_w = '{default: 32'h0000_0000};
      repeat (6) @(posedge clk);
      {rst_n, wrst_n} <= 2'b11;
      readall();
      apb(1'b0, 12'h14C, 32'h0000_0000);
      check({lerr, q[30:0]}, 32'h8000_0000);
      for (int i = 0; i < 10; i++) begin
         mask = 2'($random(seed));
         apb(1'b1, `SEEHL_OFF_IRQ_MASK, {30'h0, mask});
         txn(i < 2 ? i[0] : 1'($random(seed)));
         build();
         check({31'h0, irq}, {31'h0, mask[0]});
         readall();
         // log words ignore writes, and a second error leaves them alone
         apb(1'b1, `SEEHL_OFF_FIRST_PTR + 12'(4 * (i % 5)), $random(seed));
         txn(1'($random(seed)));
         check({31'h0, irq}, {31'h0, |mask});
         readall();
         apb(1'b0, `SEEHL_OFF_IRQ_STAT, 32'h0000_0000);
         check(q, 32'h0000_0003);
         apb(1'b1, `SEEHL_OFF_IRQ_STAT, 32'h0000_0003);
      end
      // warm reset keeps the log, power reset clears it
      txn(1'b1);
      build();
      @(posedge clk);
      wrst_n <= 1'b0;
      repeat (2) @(posedge clk);
      wrst_n <= 1'b1;
      readall();
      apb(1'b0, `SEEHL_OFF_IRQ_STAT, 32'h0000_0000);
      check(q, 32'h0000_0000);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      exp_w = '{default: 32'h0000_0000};
      readall();
      tally_and_finish();
   end
endmodule : seehl_top_tb
